//--- verilog/dpsgc_top.sv
// Packet status registers, post-correction data port and group CRC checker.
// Assumes host pins are asynchronous; packet inputs come from the same clock.

// Small FIFO, flip-flop storage, valid/ready on both sides
module dpsgc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_push, do_pop;

  // Handshake terms and honest full/empty
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;
  // Storage write
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// Notes on behaviour
// - Status bit 7 is 0 for horizontal-only, 1 after vertical plus second pass.
// - Real-time blocks report bit 7 and bit 3 as 0.
// - Bits 6 and 5 show block and frame lock when the packet arrived.
// - Bit 4 set when correction failed or layer 2 CRC saw an error.
// - Bit 3 set when the packet was judged a parity block.
// - Bit 2 marks the frame head block, meaningful only with bit 7 clear.
// - Bit 1 shows an all-zero group CRC, sampled just before the read.
// - Bit 0 marks a real-time block, only possible in method A prime.
// - Block index register holds data block 0..189 or parity block 0..81.
// - Vertical output never carries parity blocks; index undefined under halt.
// - Both read registers update shortly before the interrupt goes active.
// - Host writes group bytes and check word to offset 6; each byte folds in.
// - Group CRC pin is high while the division register is all zero.
// - Groups are unlimited; a good group leaves the register at zero.
// - Division uses x^16 + x^12 + x^5 + 1.
// - Each packet delivers exactly 176 bits, first halfword first, in 16 bits or as low byte then high byte in 8 bits.
// - Incoming packets are 272 bits: 176 data, 14 CRC, 82 parity.
module dpsgc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Packet from the correction engine
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic [271:0] pkt_word,
  input wire logic [7:0] pkt_index,
  input wire logic pkt_vertical,
  input wire logic pkt_block_locked,
  input wire logic pkt_frame_locked,
  input wire logic pkt_corr_failed,
  input wire logic pkt_l2_error,
  input wire logic pkt_parity,
  input wire logic pkt_head,
  input wire logic pkt_realtime,
  // Mode controls from the control registers
  input wire logic [1:0] frame_method,
  input wire logic vertical_correction_halt,
  input wire logic group_check_clear,
  input wire logic wide_mode,
  input wire logic dma_en,
  input wire logic ack_strobes,
  input wire logic req_active_high,
  input wire logic ack_active_high,
  // Host parallel bus pins
  input wire logic cs_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] register_select_lines,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic transfer_ack,
  output logic transfer_request,
  // Event and check outputs
  output logic int_n,
  output logic group_check_ok
);
  dpsgc_pkg::dpsgc_state_e state_reg;
  logic [7:0] status_reg, index_reg, status_next, din2;
  logic [15:0] crc_reg, dout_reg, fifo_out_data, s1_reg, s2_reg;
  logic [175:0] buf_reg;
  logic [3:0] ptr_reg, sel2;
  logic pkt_ready_reg, int_pend_reg, int_n_reg, gc_ok_reg, oe_reg, req_reg;
  logic hi_byte_reg, strobe_prev_reg, wr_prev_reg;
  logic accept, drop, keep, rt_pkt, cs2, rd2, wr2, ack2, ack_on, strobe_now, data_sel;
  logic rd_fall, rd_rise, wr_fall, status_read;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;

  // Two-flop synchronisers for every host input pin except data_in[15:8]
  always_ff @(posedge clk) begin
    s1_reg <= {cs_n, read_strobe_n, write_strobe_n, transfer_ack, register_select_lines, data_in[7:0]};
    s2_reg <= s1_reg;
  end
  assign {cs2, rd2, wr2, ack2, sel2, din2} = s2_reg;

  // Strobe decode: RD with select, or DMA via RD or acknowledge
  assign ack_on = (ack2 == ack_active_high);
  assign strobe_now = dma_en ? (ack_strobes ? ack_on : (!rd2 && ack_on)) : (!rd2 && !cs2);
  assign data_sel = dma_en || (sel2 == dpsgc_pkg::OFF_DATA);
  assign rd_fall = strobe_now && !strobe_prev_reg;
  assign rd_rise = !strobe_now && strobe_prev_reg;
  assign wr_fall = !wr2 && wr_prev_reg && !cs2;
  assign status_read = rd_fall && !dma_en && (sel2 == dpsgc_pkg::OFF_STATUS);

  // Strobe edge history
  always_ff @(posedge clk) begin
    if (srst) begin
      strobe_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b1;
    end else begin
      strobe_prev_reg <= strobe_now;
      wr_prev_reg <= wr2;
    end
  end

  // Packet acceptance; vertical parity packets are swallowed silently
  assign accept = pkt_valid && pkt_ready_reg;
  assign drop = pkt_vertical && pkt_parity;
  assign keep = accept && !drop;
  // Real-time marking exists only in method A prime
  assign rt_pkt = pkt_realtime && (frame_method == dpsgc_pkg::METHOD_A_PRIME);

  // Status word from the packet attributes
  always_comb begin
    status_next = dpsgc_pkg::STATUS_RST;
    status_next[dpsgc_pkg::BIT_PATH] = pkt_vertical && !rt_pkt;
    status_next[dpsgc_pkg::BIT_BLOCK] = pkt_block_locked;
    status_next[dpsgc_pkg::BIT_FRAME] = pkt_frame_locked;
    status_next[dpsgc_pkg::BIT_UNCORR] = pkt_corr_failed || pkt_l2_error;
    status_next[dpsgc_pkg::BIT_PARITY] = pkt_parity && !rt_pkt;
    status_next[dpsgc_pkg::BIT_HEAD] = pkt_head && !pkt_vertical;
    status_next[dpsgc_pkg::BIT_REALTIME] = rt_pkt;
  end

  // Read registers change only on a kept packet, never on host writes
  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg <= dpsgc_pkg::STATUS_RST;
      index_reg <= dpsgc_pkg::INDEX_RST;
    end else if (keep) begin
      status_reg <= status_next;
      index_reg <= pkt_index;
    end
  end

  // Interrupt goes active one cycle after the registers settle
  always_ff @(posedge clk) begin
    if (srst) begin
      int_pend_reg <= 1'b0;
      int_n_reg <= 1'b1;
    end else begin
      int_pend_reg <= keep;
      if (int_pend_reg) begin
        int_n_reg <= 1'b0;
      end else if (keep || status_read || (rd_fall && data_sel)) begin
        int_n_reg <= 1'b1;
      end
    end
  end

  // Streamer: copy the 176 data bits into the FIFO as 11 halfwords
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= dpsgc_pkg::ST_IDLE;
      ptr_reg <= 4'h0;
      buf_reg <= '0;
      pkt_ready_reg <= 1'b1;
    end else if (keep) begin
      state_reg <= dpsgc_pkg::ST_STREAM;
      ptr_reg <= 4'h0;
      buf_reg <= pkt_word[dpsgc_pkg::PKT_RX_BITS-1 -: dpsgc_pkg::PKT_DATA_BITS];
      pkt_ready_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        dpsgc_pkg::ST_IDLE: begin
          pkt_ready_reg <= 1'b1;
        end
        dpsgc_pkg::ST_STREAM: begin
          if (fifo_in_ready) begin
            ptr_reg <= ptr_reg + 4'h1;
            buf_reg <= {buf_reg[159:0], 16'h0000};
            if (ptr_reg == dpsgc_pkg::LAST_HALFWORD) begin
              state_reg <= dpsgc_pkg::ST_IDLE;
            end
          end
          if (status_read || (ptr_reg == dpsgc_pkg::LAST_HALFWORD && fifo_in_ready)) begin
            pkt_ready_reg <= 1'b1; // Host may skip: the next packet preempts
          end
        end
      endcase
    end
  end
  assign fifo_in_valid = (state_reg == dpsgc_pkg::ST_STREAM) && !keep;
  dpsgc_fifo #(
    .WIDTH(dpsgc_pkg::FIFO_WIDTH),
    .DEPTH(dpsgc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .flush(keep),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(buf_reg[175:160]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  // Pop after the trailing edge of a full-width read or the high byte
  assign fifo_out_ready = rd_rise && data_sel && (wide_mode || hi_byte_reg);
  // Byte lane tracking in 8-bit mode
  always_ff @(posedge clk) begin
    if (srst || keep) begin
      hi_byte_reg <= 1'b0;
    end else if (rd_rise && data_sel && !wide_mode) begin
      hi_byte_reg <= !hi_byte_reg;
    end
  end

  // Read data mux, latched on the leading strobe edge
  always_ff @(posedge clk) begin
    if (srst) begin
      dout_reg <= 16'h0000;
    end else if (rd_fall) begin
      if (data_sel) begin
        dout_reg <= wide_mode ? fifo_out_data : {8'h00, hi_byte_reg ? fifo_out_data[15:8] : fifo_out_data[7:0]};
      end else if (sel2 == dpsgc_pkg::OFF_STATUS) begin
        dout_reg <= {8'h00, status_reg | (8'(gc_ok_reg) << dpsgc_pkg::BIT_GROUP_OK)};
      end else if (sel2 == dpsgc_pkg::OFF_INDEX) begin
        dout_reg <= {8'h00, index_reg};
      end else begin
        dout_reg <= 16'h0000;
      end
    end
  end

  // Bus drive and DMA request
  always_ff @(posedge clk) begin
    if (srst) begin
      oe_reg <= 1'b0;
      req_reg <= !req_active_high;
    end else begin
      oe_reg <= strobe_now;
      req_reg <= (dma_en && fifo_out_valid) == req_active_high;
    end
  end

  // Group CRC division, one byte per write, MSB first
  function automatic logic [15:0] crc_fold(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ dpsgc_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Division register: cleared by the control, fed by offset 6 writes
  always_ff @(posedge clk) begin
    if (srst || group_check_clear) begin
      crc_reg <= dpsgc_pkg::CRC_RST;
    end else if (wr_fall && sel2 == dpsgc_pkg::OFF_GROUP_CHECK) begin
      crc_reg <= crc_fold(crc_reg, din2);
    end
  end

  // Zero detect for pin and status flag
  always_ff @(posedge clk) begin
    if (srst) begin
      gc_ok_reg <= 1'b1;
    end else begin
      gc_ok_reg <= (crc_reg == 16'h0000);
    end
  end

  assign pkt_ready = pkt_ready_reg;
  assign int_n = int_n_reg;
  assign group_check_ok = gc_ok_reg;
  assign data_out = dout_reg;
  assign data_oe = oe_reg;
  assign transfer_request = req_reg;

  property p_path_rt;
    @(posedge clk) disable iff (srst) keep && rt_pkt |=> !status_reg[7] && !status_reg[3];
  endproperty
  a_path_rt: assert property (p_path_rt) else $error("realtime packet flags");
  property p_path;
    @(posedge clk) disable iff (srst) keep && !rt_pkt |=> status_reg[7] == $past(pkt_vertical);
  endproperty
  a_path: assert property (p_path) else $error("path flag wrong");
  property p_err;
    @(posedge clk) disable iff (srst) keep |=> status_reg[4] == ($past(pkt_corr_failed) || $past(pkt_l2_error));
  endproperty
  a_err: assert property (p_err) else $error("uncorrectable flag wrong");
  property p_realtime_block_flag;
    @(posedge clk) disable iff (srst) keep && frame_method != dpsgc_pkg::METHOD_A_PRIME |=> !status_reg[0];
  endproperty
  a_realtime_block_flag: assert property (p_realtime_block_flag) else $error("realtime flag outside A prime");
  property p_head;
    @(posedge clk) disable iff (srst) status_reg[7] |-> !status_reg[2];
  endproperty
  a_head: assert property (p_head) else $error("head flag with path flag");
  property p_int_after_update;
    @(posedge clk) disable iff (srst) $fell(int_n_reg) |-> $past(keep, 2);
  endproperty
  a_int_after_update: assert property (p_int_after_update) else $error("interrupt without update");
  property p_int_lead;
    @(posedge clk) disable iff (srst) keep |-> ##2 !int_n_reg;
  endproperty
  a_int_lead: assert property (p_int_lead) else $error("interrupt late");
  property p_regs_stable;
    @(posedge clk) disable iff (srst) !keep |=> $stable(status_reg) && $stable(index_reg);
  endproperty
  a_regs_stable: assert property (p_regs_stable) else $error("read register changed");
  property p_crc_pin;
    @(posedge clk) disable iff (srst) (crc_reg == 16'h0000) |=> group_check_ok;
  endproperty
  a_crc_pin: assert property (p_crc_pin) else $error("group pin low on zero");
  property p_drop;
    @(posedge clk) disable iff (srst) accept && drop |=> $stable(status_reg) ##1 !$fell(int_n_reg);
  endproperty
  a_drop: assert property (p_drop) else $error("vertical parity packet reported");
  c_packet: cover property (@(posedge clk) disable iff (srst) keep ##[1:40] fifo_out_ready);
  c_crc_good: cover property (@(posedge clk) disable iff (srst) wr_fall ##2 group_check_ok);
  c_skip: cover property (@(posedge clk) disable iff (srst) status_read ##[1:20] keep);
endmodule

//--- verilog/dpsgc_pkg.sv
// Package: register map, status bit positions, CRC and timing constants.
// Assumes a single 20 MHz clock domain for the readout block.
package dpsgc_pkg;
  // Register offsets on the four register select lines
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_INDEX = 4'h2;
  localparam logic [3:0] OFF_GROUP_CHECK = 4'h6;
  // Status register bit positions
  localparam int BIT_PATH = 7;
  localparam int BIT_BLOCK = 6;
  localparam int BIT_FRAME = 5;
  localparam int BIT_UNCORR = 4;
  localparam int BIT_PARITY = 3;
  localparam int BIT_HEAD = 2;
  localparam int BIT_GROUP_OK = 1;
  localparam int BIT_REALTIME = 0;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [15:0] CRC_RST = 16'h0000;
  // Group check generator x^16 + x^12 + x^5 + 1
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // Packet layout: 272 bits received, 176 data bits delivered
  localparam int PKT_RX_BITS = 272;
  localparam int PKT_DATA_BITS = 176;
  localparam int PKT_HALFWORDS = PKT_DATA_BITS / 16;
  localparam logic [3:0] LAST_HALFWORD = 4'(PKT_HALFWORDS - 1);
  // Highest data and parity block numbers in a frame
  localparam logic [7:0] MAX_DATA_BLOCK = 8'hbd;
  localparam logic [7:0] MAX_PARITY_BLOCK = 8'h51;
  // Frame methods
  localparam logic [1:0] METHOD_A = 2'h0;
  localparam logic [1:0] METHOD_A_PRIME = 2'h1;
  localparam logic [1:0] METHOD_B = 2'h2;
  localparam logic [1:0] METHOD_C = 2'h3;
  // Register update must land within this window before the interrupt
  localparam int CLK_PERIOD_NS = 50;
  localparam int UPDATE_WINDOW_NS = 1000000;
  localparam int UPDATE_WINDOW_CYC = UPDATE_WINDOW_NS / CLK_PERIOD_NS;
  localparam int INT_LEAD_CYC = 1;
  // Data FIFO shape
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;
  // Streamer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_STREAM = 2'b10
  } dpsgc_state_e;
endpackage

//--- testbench/dpsgc_host_model.sv
// Host CPU model for the parallel bus of the packet readout block.
// Assumes the bench drives the mode pins and calls these tasks one at a time.
module dpsgc_host_model (
  // Clock and bus answers
  input wire logic clk,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  // Bus pins driven by the host
  output logic cs_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] register_select_lines,
  output logic [15:0] data_in,
  output logic transfer_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus levels from time zero, acknowledge is active high
  initial begin
    {cs_n, read_strobe_n, write_strobe_n} = 3'h7;
    register_select_lines = 4'h0;
    data_in = 16'h0000;
    transfer_ack = 1'b0;
  end

  // Read cycle, held until the block drives the bus; x on no answer
  task automatic xfer(input bit dma, input logic [3:0] a, output logic [15:0] d);
    integer i;
    @(negedge clk);
    register_select_lines = a;
    if (dma) begin
      transfer_ack = 1'b1;
      read_strobe_n = 1'b0;
    end else begin
      cs_n = 1'b0;
      read_strobe_n = 1'b0;
    end
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (data_oe !== 1'b1 && i < 30);
    d = (i < 30) ? data_out : 16'hxxxx;
    @(negedge clk);
    {cs_n, read_strobe_n} = 2'h3;
    transfer_ack = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  // Write cycle; released data lines show the inverted last value
  task automatic wr(input logic [3:0] a, input logic [7:0] b);
    @(negedge clk);
    register_select_lines = a;
    data_in = {8'h00, b};
    cs_n = 1'b0;
    write_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    {cs_n, write_strobe_n} = 2'h3;
    data_in = ~data_in;
    repeat (4) @(negedge clk);
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the packet status, data port and group check block.
// Assumes one 20 MHz clock; bus traffic goes through the host model.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst, pkt_valid, pkt_ready, rt;
  logic [271:0] pkt_word;
  logic [7:0] pkt_index, exp_stat, exp_idx;
  logic pkt_vertical, pkt_block_locked, pkt_frame_locked, pkt_corr_failed;
  logic pkt_l2_error, pkt_parity, pkt_head, pkt_realtime;
  logic [1:0] frame_method;
  logic vertical_correction_halt, group_check_clear, wide_mode, dma_en;
  logic ack_strobes, req_active_high, ack_active_high;
  logic cs_n, read_strobe_n, write_strobe_n, data_oe, transfer_ack, transfer_request, int_n, group_check_ok;
  logic [3:0] register_select_lines;
  logic [15:0] data_in, data_out, d, crc_m;
  logic [15:0] exp_q[$];
  integer n_mismatch = 0;
  integer samples_checked = 0;
  integer seed = 57268;

  // Clock at 50 ns period
  always #25 clk = ~clk;

  dpsgc_top i_dut (.clk, .srst, .pkt_valid, .pkt_ready, .pkt_word, .pkt_index, .pkt_vertical,
    .pkt_block_locked, .pkt_frame_locked, .pkt_corr_failed, .pkt_l2_error, .pkt_parity, .pkt_head,
    .pkt_realtime, .frame_method, .vertical_correction_halt, .group_check_clear, .wide_mode, .dma_en,
    .ack_strobes, .req_active_high, .ack_active_high, .cs_n, .read_strobe_n, .write_strobe_n,
    .register_select_lines, .data_in, .data_out, .data_oe, .transfer_ack, .transfer_request, .int_n,
    .group_check_ok);

  dpsgc_host_model i_host (.clk, .data_out, .data_oe, .cs_n, .read_strobe_n, .write_strobe_n,
    .register_select_lines, .data_in, .transfer_ack);

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reference group check fold, MSB first
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
    for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? dpsgc_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction

  // Random packet offered, expected status worked out, interrupt awaited
  task automatic send_pkt;
    integer i;
    @(negedge clk);
    for (i = 0; i < 9; i++) pkt_word = {pkt_word[239:0], 32'($random(seed))};
    // Expected halfwords, first data bit first
    exp_q.delete();
    for (i = 0; i < 11; i++) exp_q.push_back(pkt_word[271 - 16 * i -: 16]);
    {pkt_vertical, pkt_block_locked, pkt_frame_locked, pkt_corr_failed, pkt_l2_error, pkt_parity, pkt_head,
      pkt_realtime} = 8'($random(seed));
    if (pkt_vertical) {pkt_parity, pkt_head} = 2'h0;
    pkt_index = 8'($unsigned($random(seed)) % (pkt_parity ? 82 : 190));
    rt = pkt_realtime && frame_method == dpsgc_pkg::METHOD_A_PRIME;
    exp_stat = {pkt_vertical & !rt, pkt_block_locked, pkt_frame_locked, pkt_corr_failed | pkt_l2_error,
      pkt_parity & !rt, pkt_head, 1'b0, rt};
    exp_idx = pkt_index;
    pkt_valid = 1'b1;
    i = 0;
    while (pkt_ready !== 1'b1 && i < 40) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    pkt_valid = 1'b0;
    i = 0;
    while (int_n !== 1'b0 && i < 20) begin
      @(negedge clk);
      i++;
    end
    check(16'(int_n), 16'h0000);
  endtask

  // Status then index, as the host does after an interrupt
  task automatic chk_regs;
    i_host.xfer(1'b0, dpsgc_pkg::OFF_STATUS, d);
    check({8'h00, d[7:0]}, {8'h00, exp_stat[7:2], crc_m == 16'h0000, exp_stat[0]});
    if (!vertical_correction_halt) begin
      i_host.xfer(1'b0, dpsgc_pkg::OFF_INDEX, d);
      check({8'h00, d[7:0]}, {8'h00, exp_idx});
    end
  endtask

  // Whole packet read, first halfword first, low byte before high byte in 8-bit mode
  task automatic read_data(input bit dma);
    logic [15:0] hw;
    for (int k = 0; k < 11; k++) begin
      hw = exp_q.pop_front();
      i_host.xfer(dma, dpsgc_pkg::OFF_DATA, d);
      check(wide_mode ? d : {8'h00, d[7:0]}, wide_mode ? hw : {8'h00, hw[7:0]});
      if (!wide_mode) begin
        i_host.xfer(dma, dpsgc_pkg::OFF_DATA, d);
        check({8'h00, d[7:0]}, {8'h00, hw[15:8]});
      end
      if (k == 0) check(16'(int_n), 16'h0001);
    end
  endtask

  // One byte into the group check, pin compared with the reference
  task automatic send_byte(input logic [7:0] b);
    i_host.wr(dpsgc_pkg::OFF_GROUP_CHECK, b);
    crc_m = fold(crc_m, b);
    check(16'(group_check_ok), 16'(crc_m == 16'h0000));
  endtask

  // Group of random bytes closed by its check word
  task automatic group(input integer n);
    logic [15:0] c;
    for (int k = 0; k < n; k++) send_byte(8'($random(seed)));
    c = crc_m;
    send_byte(c[15:8]);
    send_byte(c[7:0]);
    check(16'(group_check_ok), 16'h0001);
  endtask

  // Main sequence
  initial begin
    {pkt_valid, pkt_vertical, pkt_block_locked, pkt_frame_locked, pkt_corr_failed} = 5'h00;
    {pkt_l2_error, pkt_parity, pkt_head, pkt_realtime, rt} = 5'h00;
    pkt_word = '0;
    pkt_index = 8'h00;
    frame_method = dpsgc_pkg::METHOD_A;
    {vertical_correction_halt, group_check_clear, wide_mode, dma_en, req_active_high} = 5'h00;
    {ack_strobes, ack_active_high} = 2'h3;
    crc_m = 16'h0000;
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    check({12'h000, group_check_ok, int_n, data_oe, transfer_request}, 16'h000d);
    i_host.xfer(1'b0, 4'h3, d);
    check({8'h00, d[7:0]}, 16'h0000);
    i_host.xfer(1'b0, dpsgc_pkg::OFF_INDEX, d);
    check({8'h00, d[7:0]}, {8'h00, dpsgc_pkg::INDEX_RST});
    for (int m = 0; m < 16; m++) begin
      frame_method = 2'(m / 4);
      vertical_correction_halt = 1'($random(seed));
      send_pkt;
      chk_regs;
    end
    vertical_correction_halt = 1'b0;
    // Vertical parity packet: taken, no interrupt, registers kept
    {pkt_vertical, pkt_parity} = 2'h3;
    pkt_valid = 1'b1;
    @(negedge clk);
    pkt_valid = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(int_n), 16'h0001);
    i_host.wr(dpsgc_pkg::OFF_STATUS, 8'($random(seed)));
    i_host.wr(dpsgc_pkg::OFF_INDEX, 8'($random(seed)));
    chk_regs;
    wide_mode = 1'b1;
    send_pkt;
    repeat (12) @(negedge clk);
    check(16'(pkt_ready), 16'h0000);
    read_data(1'b0);
    chk_regs;
    wide_mode = 1'b0;
    send_pkt;
    read_data(1'b0);
    chk_regs;
    {wide_mode, dma_en, req_active_high} = 3'h7;
    send_pkt;
    repeat (4) @(negedge clk);
    check(16'(transfer_request), 16'h0001);
    read_data(1'b1);
    repeat (6) @(negedge clk);
    check(16'(transfer_request), 16'h0000);
    {ack_strobes, req_active_high} = 2'h0;
    send_pkt;
    repeat (4) @(negedge clk);
    check(16'(transfer_request), 16'h0000);
    read_data(1'b1);
    repeat (6) @(negedge clk);
    check(16'(transfer_request), 16'h0001);
    {dma_en, ack_strobes} = 2'h1;
    chk_regs;
    send_byte(8'h3c);
    group_check_clear = 1'b1;
    repeat (3) @(negedge clk);
    group_check_clear = 1'b0;
    crc_m = 16'h0000;
    repeat (2) @(negedge clk);
    check(16'(group_check_ok), 16'h0001);
    group(6);
    chk_regs;
    group(3);
    send_byte(8'h5a);
    chk_regs;
    report_and_stop;
  end

  // Watchdog against a hang
  initial begin
    #3000000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
